// [aout_seq_consts.vh]
// constants for the analog output sequencer
`ifndef AOUT_SEQ_CONSTS_VH
`define AOUT_SEQ_CONSTS_VH

// ***************************************************
// register byte offsets
// ***************************************************
`define OFS_CONTROL      8'h10
`define OFS_STATUS       8'h14
`define OFS_SAMPLE       8'h18

// ***************************************************
// sample word fields
// ***************************************************
`define SMP_DATA_MSB     15
`define SMP_TAG_LSB      16
`define SMP_TAG_MSB      17
`define SMP_GROUP_END    18
`define SMP_BURST_END    19
`define SMP_WIDTH        20

// ***************************************************
// control register fields
// ***************************************************
`define CTL_SIMUL        0
`define CTL_BURST        1
`define CTL_LOOP         2
`define CTL_CLK_LSB      4
`define CTL_CLK_MSB      5
`define CTL_SYNC_LSB     6
`define CTL_SYNC_MSB     7
`define CTL_SW_SYNC      8
`define CTL_RESET        9'h000

// ***************************************************
// clock and sync source codes
// ***************************************************
`define CLK_OFF          2'h0
`define CLK_RATE_A       2'h1
`define CLK_RATE_B       2'h2
`define CLK_EXT          2'h3
`define SYNC_RATE_A      2'h0
`define SYNC_RATE_B      2'h1
`define SYNC_EXT         2'h2
`define SYNC_SOFT        2'h3

// ***************************************************
// buffer sizing
// ***************************************************
`define BUF_DEPTH        16
`define NUM_CHANNELS     4

`endif

// [analog_output_sequencer.v]
// analog output sequencer with apb registers and sample fifo
// Overview of operation
// - sequential mode: one sample per clock to tagged channel
// - updates stop on no clocks, empty, burst end
// - simultaneous: fill holding store until group end
// - clock applies whole holding store, then refill
// - output clock from rate A, B or external
// - continuous mode runs until clocks stop or empty
// - burst mode starts on sync, ends at burst-end
// - several bursts queued; early end on empty
// - sync from rate A, B, external or software
// - software sync bit starts burst, self-clears after
// - external sync falling edge starts a burst
// - looping recirculates output samples into buffer
// - looping closes buffer to host writes
// - looping keeps samples; otherwise output samples dropped
// - each sync plays next queued burst, wrapping
// - word: data 0-15, tag 16-17, flags 18, 19
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
`include "aout_seq_consts.vh"

// ***************************************************
// sample fifo
// ***************************************************
module sample_fifo #(
  parameter WIDTH = `SMP_WIDTH,
  parameter DEPTH = `BUF_DEPTH,
  parameter AW    = 4
) (
  input  wire             i_clock,
  input  wire             i_reset,
  input  wire             i_in_valid,
  output wire             o_in_ready,
  input  wire [WIDTH-1:0] i_in_data,
  output wire             o_out_valid,
  input  wire             i_out_ready,
  output wire [WIDTH-1:0] o_out_data,
  output wire [AW:0]      o_count
);
  reg  [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg  [AW-1:0]    wr_ptr_reg;
  reg  [AW-1:0]    rd_ptr_reg;
  reg  [AW:0]      count_reg;
  wire             out_fire;
  wire             in_fire;

  assign o_out_valid = (count_reg != {(AW+1){1'b0}});
  assign out_fire    = o_out_valid & i_out_ready;
  // a pop in the same cycle frees the slot, so a full loop can recirculate
  assign o_in_ready  = (count_reg < DEPTH) | out_fire;
  assign in_fire     = i_in_valid & o_in_ready;
  assign o_out_data  = mem_reg[rd_ptr_reg];
  assign o_count     = count_reg;

  always @(posedge i_clock) begin
    if (in_fire) begin
      mem_reg[wr_ptr_reg] <= i_in_data;
    end
  end

  always @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
    end else begin
      if (in_fire) begin
        wr_ptr_reg <= (wr_ptr_reg == DEPTH - 1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
      end
      if (out_fire) begin
        rd_ptr_reg <= (rd_ptr_reg == DEPTH - 1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
      end
      if (in_fire & ~out_fire) begin
        count_reg <= count_reg + 1'b1;
      end else if (out_fire & ~in_fire) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule // sample_fifo

// ***************************************************
// sequencer top
// ***************************************************
module analog_output_sequencer #(
  parameter DEPTH = `BUF_DEPTH,
  parameter AW    = 4
) (
  input  wire        i_clock,
  input  wire        i_reset,
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [7:0]  i_paddr,
  input  wire [31:0] i_pwdata,
  output reg  [31:0] o_prdata,
  output reg         o_pready,
  output reg         o_pslverr,
  input  wire        i_rate_a_tick,
  input  wire        i_rate_b_tick,
  input  wire        i_ext_sync,
  output reg  [63:0] o_dac_data,
  output reg  [3:0]  o_dac_load
);
  localparam NCH = `NUM_CHANNELS;

  reg  [8:0]            ctrl_reg;
  reg                   ext_prev_reg;
  reg                   burst_active_reg;
  reg                   group_ready_reg;
  reg                   end_pend_reg;
  reg  [15:0]           hold_data_reg [0:NCH-1];
  reg  [NCH-1:0]        hold_valid_reg;
  wire                  simul;
  wire                  burst_en;
  wire                  loop_en;
  wire                  ext_fall;
  reg                   clock_tick;
  reg                   sync_tick;
  wire                  run;
  wire                  seq_pop;
  wire                  hold_pop;
  wire                  pop;
  wire                  apply;
  wire                  burst_done;
  wire                  sw_set;
  wire                  fifo_in_valid;
  wire                  fifo_in_ready;
  wire [`SMP_WIDTH-1:0] fifo_in_data;
  wire                  fifo_out_valid;
  wire [`SMP_WIDTH-1:0] fifo_out_data;
  wire [AW:0]           fifo_count;
  wire [1:0]            smp_tag;
  wire                  acc;
  wire                  wr_sample;
  wire                  wr_ctrl;
  wire                  mapped;

  assign simul    = ctrl_reg[`CTL_SIMUL];
  assign burst_en = ctrl_reg[`CTL_BURST];
  assign loop_en  = ctrl_reg[`CTL_LOOP];
  assign smp_tag  = fifo_out_data[`SMP_TAG_MSB:`SMP_TAG_LSB];

  // ***************************************************
  // clock and sync source selection
  // ***************************************************
  assign ext_fall = ext_prev_reg & ~i_ext_sync;

  always @* begin
    case (ctrl_reg[`CTL_CLK_MSB:`CTL_CLK_LSB])
      `CLK_RATE_A: clock_tick = i_rate_a_tick;
      `CLK_RATE_B: clock_tick = i_rate_b_tick;
      `CLK_EXT:    clock_tick = ext_fall;
      default:     clock_tick = 1'b0;
    endcase
  end

  // software sync fires on the write that sets the bit
  assign sw_set = wr_ctrl & i_pwdata[`CTL_SW_SYNC];

  always @* begin
    case (ctrl_reg[`CTL_SYNC_MSB:`CTL_SYNC_LSB])
      `SYNC_RATE_A: sync_tick = i_rate_a_tick;
      `SYNC_RATE_B: sync_tick = i_rate_b_tick;
      `SYNC_EXT:    sync_tick = ext_fall;
      `SYNC_SOFT:   sync_tick = sw_set;
      default:      sync_tick = 1'b0;
    endcase
  end

  // ***************************************************
  // transfer control
  // ***************************************************
  assign run      = ~burst_en | burst_active_reg;
  assign seq_pop  = ~simul & clock_tick & run & fifo_out_valid;
  // stop filling once a group or burst end is held
  assign hold_pop = simul & ~group_ready_reg & ~end_pend_reg & run & fifo_out_valid;
  assign pop      = seq_pop | hold_pop;
  assign apply    = simul & clock_tick & group_ready_reg;
  // an empty buffer under a clock also ends the burst early
  assign burst_done = burst_en & burst_active_reg &
                      ((seq_pop & fifo_out_data[`SMP_BURST_END]) |
                       (apply & end_pend_reg) |
                       (clock_tick & ~fifo_out_valid & ~group_ready_reg));

  // looping feeds popped words back; host writes are shut out
  assign fifo_in_valid = loop_en ? pop : wr_sample;
  assign fifo_in_data  = loop_en ? fifo_out_data : i_pwdata[`SMP_WIDTH-1:0];

  sample_fifo #(
    .WIDTH (`SMP_WIDTH),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_fifo (
    .i_clock     (i_clock),
    .i_reset     (i_reset),
    .i_in_valid  (fifo_in_valid),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (fifo_in_data),
    .o_out_valid (fifo_out_valid),
    .i_out_ready (pop),
    .o_out_data  (fifo_out_data),
    .o_count     (fifo_count)
  );

  always @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      ext_prev_reg     <= 1'b1;
      burst_active_reg <= 1'b0;
      group_ready_reg  <= 1'b0;
      end_pend_reg     <= 1'b0;
      hold_valid_reg   <= {NCH{1'b0}};
      o_dac_load       <= {NCH{1'b0}};
    end else begin
      ext_prev_reg <= i_ext_sync;
      // a new sync wins over the end of the previous burst
      if (burst_en & sync_tick) begin
        burst_active_reg <= 1'b1;
      end else if (burst_done) begin
        burst_active_reg <= 1'b0;
      end
      o_dac_load <= {NCH{1'b0}};
      if (seq_pop) begin
        o_dac_load[smp_tag] <= 1'b1;
      end
      if (apply) begin
        o_dac_load      <= hold_valid_reg;
        hold_valid_reg  <= {NCH{1'b0}};
        group_ready_reg <= 1'b0;
        end_pend_reg    <= 1'b0;
      end else if (hold_pop) begin
        hold_valid_reg[smp_tag] <= 1'b1;
        if (fifo_out_data[`SMP_GROUP_END]) begin
          group_ready_reg <= 1'b1;
        end
        if (burst_en & fifo_out_data[`SMP_BURST_END]) begin
          group_ready_reg <= 1'b1;
          end_pend_reg    <= 1'b1;
        end
      end
    end
  end

  // ***************************************************
  // per-channel dac and holding data
  // ***************************************************
  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch = ch + 1) begin : g_ch
      always @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
          hold_data_reg[ch]        <= 16'h0000;
          o_dac_data[ch*16 +: 16]  <= 16'h0000;
        end else begin
          if (hold_pop && smp_tag == ch) begin
            hold_data_reg[ch] <= fifo_out_data[`SMP_DATA_MSB:0];
          end
          if (seq_pop && smp_tag == ch) begin
            o_dac_data[ch*16 +: 16] <= fifo_out_data[`SMP_DATA_MSB:0];
          end else if (apply && hold_valid_reg[ch]) begin
            o_dac_data[ch*16 +: 16] <= hold_data_reg[ch];
          end
        end
      end
    end
  endgenerate

  // ***************************************************
  // apb slave
  // ***************************************************
  assign acc       = i_psel & i_penable & o_pready;
  assign mapped    = (i_paddr == `OFS_CONTROL) | (i_paddr == `OFS_STATUS) |
                     (i_paddr == `OFS_SAMPLE);
  assign wr_ctrl   = acc & i_pwrite & (i_paddr == `OFS_CONTROL);
  // when looping the write completes but the word is dropped
  assign wr_sample = acc & i_pwrite & (i_paddr == `OFS_SAMPLE) & ~loop_en;

  always @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      ctrl_reg  <= `CTL_RESET;
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h00000000;
    end else begin
      // full buffer holds pready low: back-pressure onto the host
      o_pready  <= i_psel & i_penable & ~o_pready &
                   ~(i_pwrite & (i_paddr == `OFS_SAMPLE) & ~loop_en & ~fifo_in_ready);
      o_pslverr <= i_psel & i_penable & ~o_pready & ~mapped;
      o_prdata  <= 32'h00000000;
      // read data only alongside pready, zero otherwise
      if (i_psel & i_penable & ~i_pwrite & ~o_pready) begin
        if (i_paddr == `OFS_CONTROL) begin
          o_prdata <= {23'h000000, ctrl_reg};
        end else if (i_paddr == `OFS_STATUS) begin
          o_prdata <= {16'h0000, hold_valid_reg, end_pend_reg, group_ready_reg,
                       burst_active_reg, fifo_out_valid, {(7-AW){1'b0}}, fifo_count};
        end
      end
      if (wr_ctrl) begin
        ctrl_reg[7:0] <= i_pwdata[7:0];
      end
      // set wins over the self-clear
      if (sw_set) begin
        ctrl_reg[`CTL_SW_SYNC] <= 1'b1;
      end else if (burst_done) begin
        ctrl_reg[`CTL_SW_SYNC] <= 1'b0;
      end
    end
  end
endmodule // analog_output_sequencer

// [aout_seq_properties.sv]
// assertion checker for the analog output sequencer ports
`timescale 1ns/1ns
`include "aout_seq_consts.vh"
module aout_seq_checker #(
  parameter DEPTH = `BUF_DEPTH,
  parameter AW    = 4
) (
  input wire        i_clock,
  input wire        i_reset,
  input wire        i_psel,
  input wire        i_penable,
  input wire        i_pwrite,
  input wire [7:0]  i_paddr,
  input wire [31:0] i_pwdata,
  input wire [31:0] o_prdata,
  input wire        o_pready,
  input wire        o_pslverr,
  input wire        i_rate_a_tick,
  input wire        i_rate_b_tick,
  input wire        i_ext_sync,
  input wire [63:0] o_dac_data,
  input wire [3:0]  o_dac_load
);
  // *******************************
  // shadow of the control register
  // *******************************
  reg  [8:0] ctl_reg;
  reg        ext_reg;
  wire       rd_done = o_pready && !i_pwrite;
  wire       mapped  = i_paddr == `OFS_CONTROL || i_paddr == `OFS_STATUS ||
                       i_paddr == `OFS_SAMPLE;
  wire [1:0] clk_sel = ctl_reg[`CTL_CLK_MSB:`CTL_CLK_LSB];
  wire       sel_tick = clk_sel == `CLK_RATE_A ? i_rate_a_tick :
                        clk_sel == `CLK_RATE_B ? i_rate_b_tick :
                        clk_sel == `CLK_EXT && ext_reg && !i_ext_sync;
  always @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      ctl_reg <= `CTL_RESET;
      ext_reg <= 1'b1;
    end else begin
      ext_reg <= i_ext_sync;
      if (i_psel && i_penable && o_pready && i_pwrite && i_paddr == `OFS_CONTROL) begin
        ctl_reg <= i_pwdata[8:0];
      end
    end
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);
  a_ready_single: assert property (o_pready |=> !o_pready) else $error("pready too long");
  a_ready_access: assert property (o_pready |-> i_psel && i_penable)
    else $error("pready outside access");
  a_err_unmapped: assert property (o_pready |-> o_pslverr == !mapped)
    else $error("pslverr wrong for address");
  a_err_alone: assert property (o_pslverr |-> o_pready) else $error("pslverr without pready");
  a_rdata_quiet: assert property (!o_pready |-> o_prdata == 32'h0) else $error("stray rdata");
  a_ctrl_readback: assert property (rd_done && i_paddr == `OFS_CONTROL |->
    o_prdata[7:0] == ctl_reg[7:0]) else $error("control readback differs");
  a_status_flags: assert property (rd_done && i_paddr == `OFS_STATUS |->
    o_prdata[8] == (o_prdata[4:0] != 5'h00)) else $error("nonempty flag vs count");
  a_sample_zero: assert property (rd_done && i_paddr == `OFS_SAMPLE |-> o_prdata == 32'h0)
    else $error("sample port read not zero");
  a_seq_onehot: assert property (
    !$past(ctl_reg[0]) && !ctl_reg[0] |-> $onehot0(o_dac_load))
    else $error("several loads in sequential mode");
  a_load_tick: assert property (
    o_dac_load != 4'h0 |-> $past(sel_tick)) else $error("load without selected clock");
  a_data_holds: assert property (
    o_dac_load == 4'h0 |-> $stable(o_dac_data)) else $error("dac data moved without load");
  c_seq_load: cover property (o_dac_load != 4'h0 && !ctl_reg[0]);
  c_group_load: cover property ($countones(o_dac_load) > 1);
  c_unmapped: cover property (o_pslverr);
endmodule // aout_seq_checker

bind analog_output_sequencer aout_seq_checker #(.DEPTH(DEPTH), .AW(AW)) u_aout_seq_checker (
  .i_clock(i_clock), .i_reset(i_reset), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
  .o_pready(o_pready), .o_pslverr(o_pslverr), .i_rate_a_tick(i_rate_a_tick),
  .i_rate_b_tick(i_rate_b_tick), .i_ext_sync(i_ext_sync), .o_dac_data(o_dac_data),
  .o_dac_load(o_dac_load));

// [dac_model.sv]
// model of the four dac channels behind the sequencer
`timescale 1ns/1ns
module dac_model (
  input wire        i_clock,
  input wire        i_reset,
  input wire [63:0] i_dac_data,
  input wire [3:0]  i_dac_load
);
  reg [15:0] level [0:3];
  integer    hits  [0:3];
  integer    n;
  // counts kept so the bench sees extra or missing updates
  always @(posedge i_clock or posedge i_reset) begin
    for (n = 0; n < 4; n = n + 1) begin
      if (i_reset) begin
        level[n] <= 16'h0000;
        hits[n]  <= 0;
      end else if (i_dac_load[n]) begin
        level[n] <= i_dac_data[16*n +: 16];
        hits[n]  <= hits[n] + 1;
      end
    end
  end
endmodule // dac_model

// [tb.sv]
// self-checking testbench for the analog output sequencer
`timescale 1ns/1ns
`include "aout_seq_consts.vh"
module tb;
  reg         i_clock, i_reset, i_psel, i_penable, i_pwrite, err;
  reg         i_rate_a_tick, i_rate_b_tick, i_ext_sync;
  reg  [7:0]  i_paddr;
  reg  [31:0] i_pwdata, rd, c;
  reg  [31:0] w [0:3];
  wire [31:0] o_prdata;
  wire        o_pready, o_pslverr;
  wire [63:0] o_dac_data;
  wire [3:0]  o_dac_load;
  integer     err_total, checked, cyc, waited, t, i, k, h;
  analog_output_sequencer u_analog_output_sequencer (
    .i_clock(i_clock), .i_reset(i_reset), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_rate_a_tick(i_rate_a_tick),
    .i_rate_b_tick(i_rate_b_tick), .i_ext_sync(i_ext_sync), .o_dac_data(o_dac_data),
    .o_dac_load(o_dac_load));
  dac_model u_dac_model (.i_clock(i_clock), .i_reset(i_reset), .i_dac_data(o_dac_data),
    .i_dac_load(o_dac_load));
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  // ********************
  // bus and check tasks
  // ********************
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task chk_dac(input integer ch, input [15:0] exp);
    chk({16'h0000, u_dac_model.level[ch]}, {16'h0000, exp});
  endtask
  function integer hits();
    hits = u_dac_model.hits[0] + u_dac_model.hits[1] + u_dac_model.hits[2] +
           u_dac_model.hits[3];
  endfunction
  task apb(input wr, input [7:0] a, input [31:0] d);
    begin
      waited = 0;
      i_psel <= 1'b1;
      i_pwrite <= wr;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_clock);
      i_penable <= 1'b1;
      @(posedge i_clock);
      // read at the edge, before that edge's own updates land
      while (o_pready !== 1'b1 && waited < 200) begin
        waited = waited + 1;
        @(posedge i_clock);
      end
      if (waited >= 200) err_total = err_total + 1;
      rd = o_prdata;
      err = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
      @(posedge i_clock);
    end
  endtask
  task tick(input integer s);
    begin
      if (s == `CLK_RATE_A) i_rate_a_tick <= 1'b1;
      else if (s == `CLK_RATE_B) i_rate_b_tick <= 1'b1;
      else i_ext_sync <= 1'b0;
      @(posedge i_clock);
      i_rate_a_tick <= 1'b0;
      i_rate_b_tick <= 1'b0;
      i_ext_sync <= 1'b1;
      repeat (3) @(posedge i_clock);
    end
  endtask
  task sync(input integer s);
    if (s == `SYNC_SOFT) begin
      apb(1, `OFS_CONTROL, c | 32'h100);
      apb(0, `OFS_CONTROL, 0);
      chk(rd[8], 1);
    end else tick(s + 1);
  endtask
  task rst;
    begin
      i_reset <= 1'b1;
      repeat (8) @(posedge i_clock);
      i_reset <= 1'b0;
      @(posedge i_clock);
    end
  endtask
  task tdone;
    begin
      t = t + 1;
      $display("test %0d ends after %0d checks", t, checked);
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask
  always @(posedge i_clock) begin
    cyc = cyc + 1;
    if (cyc == 6000) begin
      err_total = err_total + 1;
      report_and_stop;
    end
  end
  // ********************
  // main sequence
  // ********************
  initial begin
    {i_psel, i_penable, i_pwrite, i_rate_a_tick, i_rate_b_tick} = 5'h00;
    i_paddr = 8'h00;
    i_pwdata = 32'h0;
    i_ext_sync = 1'b1;
    {err_total, checked, cyc, t} = 128'h0;
    i = $urandom(68078);
    rst;
    apb(0, `OFS_CONTROL, 0);
    chk(rd, `CTL_RESET);
    apb(1, `OFS_CONTROL, 32'hB5);
    apb(0, `OFS_CONTROL, 0);
    chk(rd, 32'hB5);
    apb(0, 8'h3C, 0);
    chk(err, 1);
    apb(0, `OFS_SAMPLE, 0);
    chk(rd, 0);
    tdone;
    rst;
    for (k = 1; k < 4; k = k + 1) begin
      apb(1, `OFS_CONTROL, k << `CTL_CLK_LSB);
      for (i = 0; i < 2; i = i + 1) begin
        w[i] = $urandom & 32'h3FFFF;
        apb(1, `OFS_SAMPLE, w[i]);
      end
      for (i = 0; i < 2; i = i + 1) begin
        tick(k);
        chk_dac(w[i][17:16], w[i][15:0]);
      end
      h = hits();
      tick(k);
      chk(hits(), h);
      apb(0, `OFS_STATUS, 0);
      chk(rd & 32'h1F, 0);
    end
    tdone;
    rst;
    apb(1, `OFS_CONTROL, 32'h11);
    for (i = 0; i < 4; i = i + 1) begin
      w[i] = ($urandom & 32'hFFFF) | (i == 2 ? 32'h50000 : i == 3 ? 32'h60000 : 0);
      apb(1, `OFS_SAMPLE, w[i]);
    end
    tick(1);
    chk_dac(0, w[1][15:0]);
    chk_dac(1, w[2][15:0]);
    chk(u_dac_model.hits[0], 1);
    chk(u_dac_model.hits[2], 0);
    tick(1);
    chk_dac(2, w[3][15:0]);
    tdone;
    for (k = 0; k < 4; k = k + 1) begin
      rst;
      c = 32'h2 | (k << `CTL_SYNC_LSB) | ((k < 2 ? 3 : 1) << `CTL_CLK_LSB);
      apb(1, `OFS_CONTROL, c);
      for (i = 0; i < 3; i = i + 1) begin
        w[i] = ($urandom & 32'hFFFF) | (i << 16) | (i == 1 ? 32'h80000 : 0);
        apb(1, `OFS_SAMPLE, w[i]);
      end
      tick(c[5:4]);
      chk(hits(), 0);
      sync(k);
      for (i = 0; i < 3; i = i + 1) begin
        tick(c[5:4]);
        chk(hits(), i < 2 ? i + 1 : 2);
      end
      apb(0, `OFS_CONTROL, 0);
      chk(rd[8], 0);
      sync(k);
      tick(c[5:4]);
      chk_dac(2, w[2][15:0]);
    end
    tdone;
    rst;
    apb(1, `OFS_CONTROL, 0);
    for (i = 0; i < 3; i = i + 1) begin
      w[i] = $urandom & 32'hFFFF;
      if (i == 2) apb(1, `OFS_CONTROL, 32'h4);
      apb(1, `OFS_SAMPLE, w[i]);
    end
    apb(1, `OFS_CONTROL, 32'h14);
    for (i = 0; i < 4; i = i + 1) begin
      tick(1);
      chk_dac(0, w[i % 2][15:0]);
    end
    apb(0, `OFS_STATUS, 0);
    chk(rd & 32'h1F, 2);
    tdone;
    rst;
    apb(1, `OFS_CONTROL, 32'h10);
    for (i = 0; i < 16; i = i + 1) apb(1, `OFS_SAMPLE, $urandom & 32'h3FFFF);
    apb(0, `OFS_STATUS, 0);
    chk(rd & 32'h1F, 16);
    fork
      apb(1, `OFS_SAMPLE, 32'h0);
      begin
        repeat (30) @(posedge i_clock);
        tick(1);
      end
    join
    chk(waited > 20, 1);
    for (i = 0; i < 17; i = i + 1) tick(1);
    chk(hits(), 17);
    apb(0, `OFS_STATUS, 0);
    chk(rd & 32'h1F, 0);
    tdone;
    report_and_stop;
  end
endmodule // tb
